// file: slpc_core.sv
// Programming mode command decoder, reply generator and OTP burn sequencer
`timescale 1ns/10ps
module slpc_core #(
   parameter int ARRAY_BYTES = 32,
   parameter int ARRAY_START_DELAY_NS = 20000,
   parameter int STATUS_BYTE = 31
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire slpc_pkg::slpc_cmd_t cmd,
   input wire logic rx_timeout,
   input wire logic sync_pulse,
   input wire logic [ARRAY_BYTES-1:0] write_lock,
   input wire logic otp_burn_done,
   input wire logic otp_burn_ok,
   input wire logic [ARRAY_BYTES-1:0][7:0] otp_image,
   output slpc_pkg::slpc_reply_t reply,
   output logic prog_mode,
   output logic otp_burn,
   output logic otp_load_ok_flag,
   output logic [ARRAY_BYTES-1:0][7:0] shadow_image
);
   import slpc_pkg::*;

   localparam int DELAY_RAW = (ARRAY_START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DELAY_CYC = (DELAY_RAW < 1) ? 1 : DELAY_RAW;

   //////////////////////////////////////////////////////////////////////////////////
   // CRC over the message bits, then three augmenting zeros
   function automatic logic [2:0] crc3(input logic [LONG_MSG_BITS-1:0] msg, input int n);
      logic [2:0] c;
      logic fb;
      c = CRC_SEED;
      for (int i = 0; i < LONG_MSG_BITS + CRC_AUGMENT; i++) begin
         if (i < n + CRC_AUGMENT) begin
            fb = c[2] ^ ((i < n) ? msg[i] : 1'b0);
            c = {c[1], c[0] ^ fb, fb};
         end
      end
      return c;
   endfunction

   // Reply word carrying a fault code in its low bits
   function automatic logic [9:0] fault_word(input logic [3:0] code);
      return {6'h00, code};
   endfunction

   //////////////////////////////////////////////////////////////////////////////////
   slpc_burn_t burn_q;
   logic [31:0] delay_q;
   logic [2:0][9:0] queue_q;
   logic [1:0] left_q;
   logic [LONG_MSG_BITS-1:0] msg;
   logic [4:0] byte_idx;
   logic [7:0] cur_byte;
   logic [7:0] new_byte;
   logic [7:0] next_byte;
   logic load;
   logic [2:0][9:0] load_words;
   logic [1:0] load_count;
   logic do_write;
   logic do_exec;
   logic do_enter;
   logic crc_ok;

   function automatic logic [7:0] read_byte(input logic [4:0] idx,
                                           input logic [ARRAY_BYTES-1:0][7:0] arr,
                                           input logic flag);
      logic [7:0] v;
      v = 8'h00;
      if (int'(idx) == STATUS_BYTE) begin
         v = {7'h00, flag};
      end else if (int'(idx) < ARRAY_BYTES) begin
         v = arr[idx];
      end
      return v;
   endfunction

   //////////////////////////////////////////////////////////////////////////////////
   // Command decode
   always_comb begin
      msg = {cmd.nibble_data, cmd.nibble_address, cmd.function_code, cmd.sensor_select};
      crc_ok = (crc3(msg, cmd.is_long ? LONG_MSG_BITS : SHORT_MSG_BITS) == cmd.crc);
      byte_idx = cmd.nibble_address[5:1];
      cur_byte = read_byte(byte_idx, shadow_image, otp_load_ok_flag);
      new_byte = cmd.nibble_address[0] ? {cmd.nibble_data, cur_byte[3:0]}
                                       : {cur_byte[7:4], cmd.nibble_data};
      next_byte = (int'(byte_idx) >= ARRAY_BYTES - 1) ? 8'h00
                  : read_byte(byte_idx + 5'h01, shadow_image, otp_load_ok_flag);
      load = 1'b0;
      load_words = '0;
      load_count = SHORT_REPLY_WORDS;
      do_write = 1'b0;
      do_exec = 1'b0;
      do_enter = 1'b0;
      if (rx_timeout) begin
         load = 1'b1;
         load_words = {REPLY_ZERO, fault_word(FAULT_FRAMING), REPLY_ERROR};
      end else if (cmd_valid && burn_q != BURN_RUN) begin
         if (cmd.framing_err) begin
            load = !cmd.is_xlong;
            load_count = cmd.is_long ? LONG_REPLY_WORDS : SHORT_REPLY_WORDS;
            load_words = {REPLY_ZERO, fault_word(FAULT_FRAMING), REPLY_ERROR};
         end else if (cmd.is_xlong || cmd.sensor_select != OWN_SENSOR_SELECT) begin
            load = 1'b0;
         end else if (!crc_ok) begin
            // Short enter command and short invalid codes stay silent even when corrupted
            load = cmd.is_long || cmd.function_code == FC_EXEC_NVM;
            load_count = cmd.is_long ? LONG_REPLY_WORDS : SHORT_REPLY_WORDS;
            load_words = {REPLY_ZERO, fault_word(FAULT_CRC), REPLY_ERROR};
         end else if (!cmd.is_long) begin
            if (cmd.function_code == FC_EXEC_NVM) begin
               load = 1'b1;
               do_exec = 1'b1;
               load_words = {REPLY_ZERO, REPLY_EXEC_OK, REPLY_OK};
            end else if (cmd.function_code == FC_ENTER_PROG) begin
               load = 1'b1;
               do_enter = 1'b1;
               load_words = {REPLY_ZERO, REPLY_ENTER_OK, REPLY_OK};
            end
         end else begin
            load_count = LONG_REPLY_WORDS;
            if (cmd.function_code == FC_NIBBLE_READ || cmd.function_code == FC_NIBBLE_WRITE) begin
               load = 1'b1;
               // Status byte sits outside the array but stays addressable
               if (int'(byte_idx) >= ARRAY_BYTES && int'(byte_idx) != STATUS_BYTE) begin
                  load_words = {REPLY_ZERO, fault_word(FAULT_RANGE), REPLY_ERROR};
               end else if (cmd.function_code == FC_NIBBLE_READ) begin
                  load_words = {2'b00, next_byte, 2'b00, cur_byte, REPLY_OK};
               end else if (int'(byte_idx) == STATUS_BYTE || write_lock[byte_idx]) begin
                  load_words = {REPLY_ZERO, fault_word(FAULT_LOCKED), REPLY_ERROR};
               end else begin
                  do_write = 1'b1;
                  load_words = {4'h0, cmd.nibble_address, 2'b00, new_byte, REPLY_OK};
               end
            end
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////////
   // Reply queue, one word per sync pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         queue_q <= '0;
         left_q <= 2'h0;
         reply <= '0;
      end else begin
         reply.valid <= 1'b0;
         if (load) begin
            queue_q <= load_words;
            left_q <= load_count;
         end else if (sync_pulse && left_q != 2'h0 && burn_q != BURN_RUN) begin
            reply.valid <= 1'b1;
            reply.word <= queue_q[0];
            reply.parity <= ^queue_q[0];
            queue_q <= {REPLY_ZERO, queue_q[2], queue_q[1]};
            left_q <= left_q - 2'h1;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////////
   // Shadow array; rejected writes never reach this path
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shadow_image <= '0;
      end else if (burn_q == BURN_RUN && otp_burn_done && otp_burn_ok) begin
         shadow_image <= otp_image;
      end else if (do_write) begin
         shadow_image[byte_idx] <= new_byte;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_mode <= 1'b0;
      end else if (do_enter) begin
         prog_mode <= 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////
   // OTP burn sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         burn_q <= BURN_IDLE;
         delay_q <= 32'h0;
         otp_burn <= 1'b0;
         otp_load_ok_flag <= 1'b0;
      end else begin
         unique case (burn_q)
            BURN_IDLE: begin
               if (do_exec) begin
                  burn_q <= BURN_WAIT;
                  delay_q <= 32'(DELAY_CYC - 1);
                  otp_load_ok_flag <= 1'b0;
               end
            end
            BURN_WAIT: begin
               if (delay_q == 32'h0) begin
                  burn_q <= BURN_RUN;
                  otp_burn <= 1'b1;
               end else begin
                  delay_q <= delay_q - 32'h1;
               end
            end
            BURN_RUN: begin
               if (otp_burn_done) begin
                  burn_q <= BURN_IDLE;
                  otp_burn <= 1'b0;
                  otp_load_ok_flag <= otp_burn_ok;
               end
            end
         endcase
      end
   end
endmodule

// file: slpc_core_asserts.sv
// Port-level checks of the programming command core
`timescale 1ns/10ps
module slpc_core_asserts #(parameter int ARRAY_BYTES = 32) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire slpc_pkg::slpc_cmd_t cmd,
   input wire logic rx_timeout,
   input wire logic sync_pulse,
   input wire logic otp_burn_done,
   input wire logic otp_burn_ok,
   input wire logic [ARRAY_BYTES-1:0][7:0] otp_image,
   input wire slpc_pkg::slpc_reply_t reply,
   input wire logic prog_mode,
   input wire logic otp_burn,
   input wire logic otp_load_ok_flag,
   input wire logic [ARRAY_BYTES-1:0][7:0] shadow_image
);
   import slpc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_parity; reply.valid |-> reply.parity == ^reply.word; endproperty
   a_parity: assert property (p_parity) else $error("reply parity odd");
   property p_word; reply.valid |-> $past(sync_pulse) && !$past(otp_burn); endproperty
   a_word: assert property (p_word) else $error("reply without usable sync");
   // Burn may start between timeout and sync, which mutes the sync
   property p_timeout;
      rx_timeout && !otp_burn ##1 sync_pulse && !cmd_valid && !rx_timeout && !otp_burn
         |=> reply.valid && reply.word == REPLY_ERROR;
   endproperty
   a_timeout: assert property (p_timeout) else $error("no error after timeout");
   property p_burn_hold; otp_burn && !otp_burn_done |=> otp_burn; endproperty
   a_burn_hold: assert property (p_burn_hold) else $error("burn ended early");
   property p_burn_end;
      otp_burn && otp_burn_done |=> !otp_burn && otp_load_ok_flag == $past(otp_burn_ok);
   endproperty
   a_burn_end: assert property (p_burn_end) else $error("burn end wrong");
   property p_refresh;
      otp_burn && otp_burn_done && otp_burn_ok |=> shadow_image == $past(otp_image);
   endproperty
   a_refresh: assert property (p_refresh) else $error("shadow not refreshed");
   property p_mode; prog_mode |=> prog_mode; endproperty
   a_mode: assert property (p_mode) else $error("mode dropped");
   property p_enter;
      $rose(prog_mode) |-> $past(cmd_valid) && $past(cmd.function_code) == FC_ENTER_PROG;
   endproperty
   a_enter: assert property (p_enter) else $error("mode without enter");
   property p_still;
      !(cmd_valid && cmd.is_long) && !otp_burn_done |=> $stable(shadow_image);
   endproperty
   a_still: assert property (p_still) else $error("shadow changed");
endmodule
bind slpc_core slpc_core_asserts #(.ARRAY_BYTES(ARRAY_BYTES)) chk_u (.clk, .rst_n, .cmd_valid,
   .cmd, .rx_timeout, .sync_pulse, .otp_burn_done, .otp_burn_ok, .otp_image, .reply,
   .prog_mode, .otp_burn, .otp_load_ok_flag, .shadow_image);

// file: slpc_core_test.sv
// Self-checking bench of the programming command core
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
   $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module slpc_core_test;
   import slpc_pkg::*;
   localparam int AB = 20;
   localparam int DLY = 10;
   logic clk = 0, rst_n = 0, cmd_valid = 0, rx_timeout = 0, sync_pulse = 0, burn_ok = 1;
   slpc_cmd_t cmd = '0;
   logic [AB-1:0] write_lock = '0;
   logic otp_burn_done, otp_burn_ok, prog_mode, otp_burn, otp_load_ok_flag;
   logic [AB-1:0][7:0] otp_image, shadow_image;
   slpc_reply_t reply;
   logic [7:0] mem [AB] = '{default: 8'h00};
   logic [5:0] a;
   time te;
   int failures = 0, checks_done = 0;
   int knd[6] = '{0, 0, 2, 2, 0, 1}, fcs[6] = '{5, 6, 0, 1, 7, 3};
   int ek[6] = '{1, 1, 1, 1, 1, 0}, ef[6] = '{3, 3, 3, 2, 2, 4};
   int ea[6] = '{7, 2 * AB, 62, 5, 5, 0}, eb[6] = '{0, 0, 0, 1, 2, 1};
   logic [3:0] ec[6] = '{FAULT_LOCKED, FAULT_RANGE, FAULT_LOCKED, FAULT_CRC, FAULT_FRAMING,
      FAULT_CRC};
   slpc_core #(.ARRAY_BYTES(AB), .ARRAY_START_DELAY_NS(DLY * 4)) dut_u (.clk, .rst_n,
      .cmd_valid, .cmd, .rx_timeout, .sync_pulse, .write_lock, .otp_burn_done, .otp_burn_ok,
      .otp_image, .reply, .prog_mode, .otp_burn, .otp_load_ok_flag, .shadow_image);
   slpc_otp_model #(.AB(AB)) otp_u (.clk, .otp_burn, .burn_ok, .otp_burn_done, .otp_burn_ok,
      .otp_image);
   initial forever #(CLK_PERIOD_NS / 2) clk = ~clk;
   function automatic logic [2:0] crc_of(logic [15:0] bits, int n);
      logic [2:0] c;
      logic fb;
      c = CRC_SEED;
      for (int i = 0; i < n + CRC_AUGMENT; i++) begin
         fb = c[2] ^ (i < n ? bits[i] : 1'b0);
         c = {c[1], c[0] ^ fb, fb};
      end
      return c;
   endfunction
   function automatic logic [9:0] nxt(logic [5:0] ad);
      return (ad >> 1) + 1 < AB ? {2'b0, mem[(ad >> 1) + 1]} : REPLY_ZERO;
   endfunction
   task automatic send(bit [1:0] k, bit [2:0] sa, fc, bit [5:0] ad, bit [3:0] d, bit [1:0] bad);
      @(negedge clk);
      cmd = '0;
      cmd.is_long = k == 1;
      cmd.is_xlong = k == 2;
      // Stuffing faults of the master reach the core only as a framing fault
      cmd.framing_err = bad[1];
      {cmd.sensor_select, cmd.function_code, cmd.nibble_address, cmd.nibble_data} = {sa, fc, ad, d};
      cmd.crc = crc_of({d, ad, fc, sa}, k == 1 ? LONG_MSG_BITS : SHORT_MSG_BITS) ^ {2'b0, bad[0]};
      cmd_valid = 1;
      @(negedge clk);
      cmd_valid = 0;
   endtask
   task automatic word(logic [9:0] w, bit v = 1);
      @(negedge clk);
      sync_pulse = 1;
      rx_timeout = 0;
      @(negedge clk);
      sync_pulse = 0;
      `CHK(reply.valid, v)
      if (v) `CHK(reply.word, w)
   endtask
   task automatic rep(logic [9:0] x, y, z, int n);
      word(x);
      word(y);
      if (n == 3) word(z);
   endtask
   task automatic summarize();
      $display("failures %0d checks_done %0d", failures, checks_done);
      if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      // The tests need about five hundred cycles
      #(20000 * CLK_PERIOD_NS);
      failures++;
      summarize();
   end
   initial begin
      void'($urandom(79));
      repeat (12) @(negedge clk);
      rst_n = 1;
      send(0, 1, FC_ENTER_PROG, 0, 0, 0);
      rep(REPLY_OK, REPLY_ENTER_OK, 0, 2);
      `CHK(prog_mode, 1'b1)
      // Commands that must load nothing, so a sync finds the queue empty
      for (int k = 0; k < 6; k++) begin
         send(2'(knd[k]), k == 5 ? 3'h2 : 3'h1, 3'(fcs[k]), 0, 4'hF, {1'b0, k == 4});
         word(0, 0);
      end
      for (int n = 0; n < 20; n++) begin
         a = 6'($urandom_range(2 * AB - 1));
         send(1, 1, FC_NIBBLE_WRITE, a, 4'($urandom), 0);
         if (a[0]) mem[a >> 1][7:4] = cmd.nibble_data;
         else mem[a >> 1][3:0] = cmd.nibble_data;
         rep(REPLY_OK, {2'b0, mem[a >> 1]}, {4'b0, a}, 3);
         a = n == 19 ? 6'(2 * AB - 1) : 6'($urandom_range(2 * AB - 1));
         send(1, 1, FC_NIBBLE_READ, a, 0, 0);
         rep(REPLY_OK, {2'b0, mem[a >> 1]}, nxt(a), 3);
      end
      write_lock[3] = 1;
      for (int k = 0; k < 6; k++) begin
         send(2'(ek[k]), 1, 3'(ef[k]), 6'(ea[k]), 4'h9, 2'(eb[k]));
         rep(REPLY_ERROR, {6'b0, ec[k]}, REPLY_ZERO, ek[k] ? 3 : 2);
      end
      foreach (mem[i]) `CHK(shadow_image[i], mem[i])
      @(negedge clk);
      rx_timeout = 1;
      rep(REPLY_ERROR, {6'b0, FAULT_FRAMING}, 0, 2);
      // Burn after loading the shadow, then read the completion flag back
      for (int ok = 1; ok >= 0; ok--) begin
         burn_ok = 1'(ok);
         send(0, 1, FC_EXEC_NVM, 0, 0, 0);
         te = $time;
         word(REPLY_OK);
         while (!otp_burn && $time < te + 400) @(negedge clk);
         `CHK(($time - te) / CLK_PERIOD_NS, DLY)
         `CHK(otp_load_ok_flag, 1'b0)
         // Second reply word is still queued, so only the burn can mute it
         word(0, 0);
         // Master waits out the burn before it talks again
         while (otp_burn && $time < te + 4000) @(negedge clk);
         `CHK(otp_burn, 1'b0)
         `CHK(otp_load_ok_flag, 1'(ok))
         word(REPLY_EXEC_OK);
         if (ok) foreach (mem[i]) mem[i] = 8'hA5 ^ 8'(i);
         foreach (mem[i]) `CHK(shadow_image[i], mem[i])
         send(1, 1, FC_NIBBLE_READ, 6'h3E, 0, 0);
         rep(REPLY_OK, 10'(ok), REPLY_ZERO, 3);
      end
      summarize();
   end
endmodule

// file: slpc_otp_model.sv
// OTP array model that ends each burn after a fixed time
`timescale 1ns/10ps
module slpc_otp_model #(parameter int AB = 20, parameter int BURN_CYC = 30) (
   input wire logic clk,
   input wire logic otp_burn,
   input wire logic burn_ok,
   output logic otp_burn_done,
   output logic otp_burn_ok,
   output logic [AB-1:0][7:0] otp_image
);
   int cnt = 0;
   // Fixed pattern so the bench can predict the shadow refresh
   always_comb for (int i = 0; i < AB; i++) otp_image[i] = 8'hA5 ^ 8'(i);
   always_ff @(posedge clk) begin
      cnt <= otp_burn ? cnt + 1 : 0;
      otp_burn_done <= otp_burn && cnt == BURN_CYC;
   end
   // Result is junk outside the done pulse, as a real macro gives no promise there
   assign otp_burn_ok = otp_burn_done ? burn_ok : ~burn_ok;
endmodule

// file: slpc_pkg.sv
// Shared constants and carrier types of the sensor link programming command block
package slpc_pkg;
   localparam int CLK_PERIOD_NS = 4;
   localparam logic [9:0] REPLY_OK = 10'h1E1;
   localparam logic [9:0] REPLY_ERROR = 10'h1E2;
   localparam logic [9:0] REPLY_EXEC_OK = 10'h2AA;
   localparam logic [9:0] REPLY_ENTER_OK = 10'h0CA;
   localparam logic [9:0] REPLY_ZERO = 10'h000;
   localparam logic [2:0] OWN_SENSOR_SELECT = 3'h1;
   localparam logic [2:0] FC_EXEC_NVM = 3'h4;
   localparam logic [2:0] FC_ENTER_PROG = 3'h7;
   localparam logic [2:0] FC_NIBBLE_READ = 3'h2;
   localparam logic [2:0] FC_NIBBLE_WRITE = 3'h3;
   localparam logic [3:0] FAULT_FRAMING = 4'h1;
   localparam logic [3:0] FAULT_CRC = 4'h2;
   localparam logic [3:0] FAULT_RANGE = 4'h5;
   localparam logic [3:0] FAULT_LOCKED = 4'h6;
   localparam logic [2:0] CRC_SEED = 3'h7;
   localparam int CRC_AUGMENT = 3;
   localparam int SHORT_MSG_BITS = 6;
   localparam int LONG_MSG_BITS = 16;
   localparam logic [1:0] SHORT_REPLY_WORDS = 2'h2;
   localparam logic [1:0] LONG_REPLY_WORDS = 2'h3;

   // One received command frame, fields in arrival order (bit 0 first)
   typedef struct packed {
      logic framing_err;
      logic is_long;
      logic is_xlong;
      logic [2:0] sensor_select;
      logic [2:0] function_code;
      logic [5:0] nibble_address;
      logic [3:0] nibble_data;
      logic [2:0] crc;
   } slpc_cmd_t;

   // One reply word towards the link transmitter
   typedef struct packed {
      logic valid;
      logic [9:0] word;
      logic parity;
   } slpc_reply_t;

   typedef enum logic [2:0] {
      BURN_IDLE = 3'b001,
      BURN_WAIT = 3'b010,
      BURN_RUN = 3'b100
   } slpc_burn_t;
endpackage
